//--- common/hsf_pkg.sv
// shared constants and types of the stream formatter control block
// assumes one 100 MHz clock and an apb master for the control registers

package hsf_pkg;

    // ************************************************************
    // stream words
    // ************************************************************
    localparam int CH_W = 10;
    localparam int WORD_W = 20;
    localparam int LN_W = 11;
    localparam int CRC_W = 18;
    localparam int PIPE_N = 5;
    localparam int FIFO_DEPTH = 16;

    // one input word with the timing marks aligned to it
    typedef struct packed {
        logic f;
        logic v;
        logic h;
        logic [9:0] y;
        logic [9:0] c;
    } hsf_word_t;

    localparam logic [9:0] TRS_ONES = 10'h3ff;
    localparam logic [9:0] TRS_ZERO = 10'h000;
    localparam logic [10:0] LN_FIRST = 11'h001;
    localparam logic [17:0] CRC_INIT = 18'h00000;

    // word positions counted from the first word of a timing code
    localparam logic [3:0] POS_XYZ = 4'h3;
    localparam logic [3:0] POS_LN0 = 4'h4;
    localparam logic [3:0] POS_LN1 = 4'h5;
    localparam logic [3:0] POS_CRC0 = 4'h6;
    localparam logic [3:0] POS_CRC1 = 4'h7;

    // bit of the xyz word that tells an end code from a start code
    localparam int XYZ_H_BIT = 6;

    // ************************************************************
    // register map
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] STAT_ADDR = 8'h04;

    typedef struct packed {
        logic det_luma;
        logic det_en;
        logic crc_en;
        logic ln_en;
        logic trs_en;
    } hsf_ctrl_t;

    localparam logic [4:0] CTRL_RST = 5'h07;
    localparam int STAT_LN_LSB = 0;
    localparam int STAT_TRIPLET_LSB = 12;
    localparam int STAT_LVL_LSB = 16;

    typedef enum logic [1:0] {
        HSF_SEL_CTRL,
        HSF_SEL_STAT,
        HSF_SEL_NONE
    } hsf_sel_t;

endpackage

//--- rtl/hsf_crc.sv
// one word step of the line check code, x^18 + x^5 + x^4 + 1, lsb first
// assumes the caller holds the running value in its own state

`timescale 1ns/10ps

module hsf_crc #(
    parameter int DW = 10,
    parameter int CW = 18
) (
    input wire logic [CW-1:0] i_crc,
    input wire logic [DW-1:0] i_data,
    output logic [CW-1:0] o_crc
);
    if (CW != 18 || DW < 1) begin : g_bad_width
        $error("hsf_crc supports only an 18 bit check code");
    end

    always_comb begin
        logic fb;
        logic [CW-1:0] c;
        fb = 1'b0;
        c = i_crc;
        for (int i = 0; i < DW; i++) begin
            fb = c[0] ^ i_data[i];
            c = {fb, c[CW-1:1]};
            c[12] = c[12] ^ fb;
            c[13] = c[13] ^ fb;
        end
        o_crc = c;
    end

endmodule

//--- rtl/hsf_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes writer and reader share the one clock

`timescale 1ns/10ps

module hsf_fifo #(
    parameter int W = 23,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_wr_valid,
    output logic o_wr_ready,
    input wire logic [W-1:0] i_wr_data,
    output logic o_rd_valid,
    input wire logic i_rd_ready,
    output logic [W-1:0] o_rd_data,
    output logic [$clog2(DEPTH):0] o_level
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("hsf_fifo depth must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [AW:0] wr_ptr;
        logic [AW:0] rd_ptr;
    } hsf_fifo_st_t;

    hsf_fifo_st_t r, n;
    logic [W-1:0] mem [DEPTH];
    logic do_wr;
    logic do_rd;

    assign o_level = r.wr_ptr - r.rd_ptr;
    // full when pointers differ only in the wrap bit
    assign o_wr_ready = (o_level != ($clog2(DEPTH)+1)'(DEPTH));
    assign o_rd_valid = (r.wr_ptr != r.rd_ptr);
    assign o_rd_data = mem[r.rd_ptr[AW-1:0]];
    assign do_wr = i_wr_valid & o_wr_ready;
    assign do_rd = o_rd_valid & i_rd_ready;

    always_comb begin
        n = r;
        if (do_wr) begin
            n.wr_ptr = r.wr_ptr + 1'b1;
        end
        if (do_rd) begin
            n.rd_ptr = r.rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    always_ff @(posedge i_clk) begin
        if (do_wr) begin
            mem[r.wr_ptr[AW-1:0]] <= i_wr_data;
        end
    end

endmodule

//--- rtl/hsf_formatter.sv
// control and output stage of the hdtv stream formatter
// assumes an upstream source pushing aligned luma/chroma words with timing
// marks, a downstream serializer taking words by valid/ready, and apb access

`timescale 1ns/10ps

module hsf_formatter #(
    parameter int FIFO_DEPTH = hsf_pkg::FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [19:0] i_video_word_in,
    input wire logic i_line_blank_mark,
    input wire logic i_picture_blank_mark,
    input wire logic i_interlace_odd_mark,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic i_line_counter_clear,
    input wire logic i_out_bus_drive_n,
    input wire logic i_out_ready,
    output logic o_out_valid,
    output logic [19:0] o_formatted_word_out,
    output logic [19:0] o_formatted_word_oe
);
    localparam int LVL_W = $clog2(FIFO_DEPTH) + 1;

    if (FIFO_DEPTH < 2 || LVL_W > 16) begin : g_bad_depth
        $error("hsf_formatter fifo depth out of range");
    end

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        // look-ahead words, pipe[4] is the oldest and leaves first
        hsf_pkg::hsf_word_t [hsf_pkg::PIPE_N-1:0] pipe;
        logic [hsf_pkg::PIPE_N-1:0] pv;
        logic [19:0] out_word;
        logic out_valid;
        logic [31:0] prdata;
        logic pslverr;
        hsf_pkg::hsf_ctrl_t ctrl;
        hsf_pkg::hsf_ctrl_t act;
        logic [3:0] pos;
        logic in_eav;
        logic in_sav;
        logic [1:0] fv;
        logic prev_h;
        logic active;
        // running check codes of the current line, one per channel
        logic [17:0] crc_y;
        logic [17:0] crc_c;
        // number of the line whose end code comes next
        logic [10:0] ln;
        // clear pin of the previous cycle, for the falling edge
        logic clr_d;
        logic [2:0] det_triplet;
    } hsf_st_t;

    hsf_st_t r, n;

    hsf_pkg::hsf_word_t in_word;
    hsf_pkg::hsf_word_t head;
    logic head_valid;
    logic adv;
    logic shift;
    // fifo fill level, read back in the status word
    logic [LVL_W-1:0] level;
    logic [9:0] oy;
    logic [9:0] oc;
    logic [17:0] crc_y_nx;
    logic [17:0] crc_c_nx;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [9:0] hsf_chan(input hsf_pkg::hsf_word_t w, input logic luma);
        hsf_chan = luma ? w.y : w.c;
    endfunction

    function automatic hsf_pkg::hsf_sel_t hsf_decode(input logic [7:0] addr);
        if (addr == hsf_pkg::CTRL_ADDR) begin
            hsf_decode = hsf_pkg::HSF_SEL_CTRL;
        end else if (addr == hsf_pkg::STAT_ADDR) begin
            hsf_decode = hsf_pkg::HSF_SEL_STAT;
        end else begin
            hsf_decode = hsf_pkg::HSF_SEL_NONE;
        end
    endfunction

    // word p of a timing code; the xyz word carries its own protection bits
    function automatic logic [9:0] hsf_trs(input logic [1:0] p, input logic f, input logic v, input logic h);
        unique case (p)
            2'h0: hsf_trs = hsf_pkg::TRS_ONES;
            2'h1, 2'h2: hsf_trs = hsf_pkg::TRS_ZERO;
            2'h3: hsf_trs = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h, 2'b00};
        endcase
    endfunction

    // ************************************************************
    // input fifo
    // ************************************************************
    // channel split
    assign in_word = '{f: i_interlace_odd_mark, v: i_picture_blank_mark, h: i_line_blank_mark,
                       y: i_video_word_in[19:10], c: i_video_word_in[9:0]};

    // the fifo fills whenever the serializer stalls; its ready is the source's back-pressure
    hsf_fifo #(
        .W($bits(hsf_pkg::hsf_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_wr_valid(i_in_valid),
        .o_wr_ready(o_in_ready),
        .i_wr_data(in_word),
        .o_rd_valid(head_valid),
        .i_rd_ready(adv),
        .o_rd_data(head),
        .o_level(level)
    );

    // a stalled output word freezes the pipe, so no word is ever dropped
    assign adv = ~r.out_valid | i_out_ready;
    assign shift = adv & head_valid;

    // check codes step on the words as they leave, after insertion
    hsf_crc u_crc_y (
        .i_crc(r.crc_y),
        .i_data(oy),
        .o_crc(crc_y_nx)
    );

    hsf_crc u_crc_c (
        .i_crc(r.crc_c),
        .i_data(oc),
        .o_crc(crc_c_nx)
    );

    // ************************************************************
    // timing code sequencing and insertion
    // ************************************************************
    // five word look-ahead: pipe[4] leaves next, pipe[1] holds the xyz word
    // of a code starting at pipe[4]; the last words wait for new input
    logic trs_hit;
    logic [9:0] det_xyz;
    logic ext_eav;
    logic ext_sav;
    logic eav_go;
    logic sav_go;
    logic seq_e;
    logic seq_s;
    logic [3:0] p;
    hsf_pkg::hsf_ctrl_t cur;
    logic [1:0] fv_now;
    hsf_pkg::hsf_word_t s4;

    assign s4 = r.pipe[4];
    assign det_xyz = hsf_chan(r.pipe[1], r.act.det_luma);
    // limitation: a code is found only once all four of its words are in the pipe
    assign trs_hit = (&r.pv[4:1]) && hsf_chan(r.pipe[4], r.act.det_luma) == hsf_pkg::TRS_ONES
                     && hsf_chan(r.pipe[3], r.act.det_luma) == hsf_pkg::TRS_ZERO
                     && hsf_chan(r.pipe[2], r.act.det_luma) == hsf_pkg::TRS_ZERO;
    // end code where the blanking mark rises
    assign ext_eav = r.pv[4] & s4.h & ~r.prev_h;
    // start code is the last four words of the blanking mark
    assign ext_sav = (&r.pv) & r.pipe[4].h & r.pipe[3].h & r.pipe[2].h & r.pipe[1].h
                     & ~r.pipe[0].h;
    assign eav_go = r.act.det_en ? trs_hit & det_xyz[hsf_pkg::XYZ_H_BIT] : ext_eav;
    assign sav_go = r.act.det_en ? trs_hit & ~det_xyz[hsf_pkg::XYZ_H_BIT] : ext_sav;
    // a code in progress goes on unless a new one starts
    assign seq_e = eav_go | (~sav_go & r.in_eav);
    assign seq_s = sav_go | (~eav_go & r.in_sav);
    // position of the leaving word within its code
    assign p = (eav_go | sav_go) ? 4'h0 : 4'(r.pos + 4'h1);
    // settings of a line taken at its end code
    assign cur = eav_go ? r.ctrl : r.act;
    // field and vertical bits from marks or from the found code
    assign fv_now = (eav_go | sav_go) ? (r.act.det_en ? det_xyz[8:7] : {s4.f, s4.v}) : r.fv;

    always_comb begin
        oy = s4.y;
        oc = s4.c;
        if ((seq_e | seq_s) && p <= hsf_pkg::POS_XYZ && cur.trs_en) begin
            oy = hsf_trs(p[1:0], fv_now[1], fv_now[0], seq_e);
            oc = oy;
        end
        if (seq_e && cur.ln_en && !cur.det_en) begin
            if (p == hsf_pkg::POS_LN0) begin
                oy = {~r.ln[6], r.ln[6:0], 2'b00};
                oc = oy;
            end else if (p == hsf_pkg::POS_LN1) begin
                oy = {1'b1, 3'b000, r.ln[10:7], 2'b00};
                oc = oy;
            end
        end
        // code, line number and check positions never overlap
        // check code words
        if (seq_e && cur.crc_en) begin
            if (p == hsf_pkg::POS_CRC0) begin
                oy = {~r.crc_y[8], r.crc_y[8:0]};
                oc = {~r.crc_c[8], r.crc_c[8:0]};
            end else if (p == hsf_pkg::POS_CRC1) begin
                oy = {~r.crc_y[17], r.crc_y[17:9]};
                oc = {~r.crc_c[17], r.crc_c[17:9]};
            end
        end
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        hsf_pkg::hsf_sel_t sel;
        sel = hsf_decode(i_paddr);
        n = r;

        if (shift) begin
            n.pipe = {r.pipe[hsf_pkg::PIPE_N-2:0], head};
            n.pv = {r.pv[hsf_pkg::PIPE_N-2:0], 1'b1};
            // one word out per accepted pixel
            n.out_valid = r.pv[4];
            // luma in the upper half, bit 19 msb
            n.out_word = {oy, oc};
        end else if (i_out_ready) begin
            n.out_valid = 1'b0;
        end

        // sequencing advances only when a real word leaves the pipe
        if (shift && r.pv[4]) begin
            n.prev_h = s4.h;
            n.pos = p;
            n.fv = fv_now;
            n.in_eav = seq_e && p < hsf_pkg::POS_CRC1;
            n.in_sav = seq_s && p < hsf_pkg::POS_XYZ;
            if (eav_go) begin
                n.act = r.ctrl;
            end
            if (trs_hit) begin
                n.det_triplet = det_xyz[8:6];
            end
            // running check over active words, end code and line number
            if (r.active) begin
                n.crc_y = crc_y_nx;
                n.crc_c = crc_c_nx;
            end
            if (seq_s && p == hsf_pkg::POS_XYZ) begin
                n.active = 1'b1;
            end
            if (seq_e && p == hsf_pkg::POS_LN1) begin
                n.active = 1'b0;
                n.ln = 11'(r.ln + 11'h001);
            end
            if (seq_e && p == hsf_pkg::POS_CRC1) begin
                n.crc_y = hsf_pkg::CRC_INIT;
                n.crc_c = hsf_pkg::CRC_INIT;
            end
        end
        // when no code came, the line stays idle outside sequences
        if (shift && r.pv[4] && !(seq_e | seq_s)) begin
            n.pos = r.pos;
        end

        // falling clear edge wins over the count
        n.clr_d = i_line_counter_clear;
        if (r.clr_d && !i_line_counter_clear) begin
            n.ln = hsf_pkg::LN_FIRST;
        end

        // with the pipe empty, as after reset, the settings follow at once
        if (r.pv == '0) begin
            n.act = r.ctrl;
        end

        // apb: read data captured in setup, write takes effect in access
        if (i_psel && !i_penable) begin
            n.pslverr = (sel == hsf_pkg::HSF_SEL_NONE);
            n.prdata = '0;
            if (!i_pwrite && sel == hsf_pkg::HSF_SEL_CTRL) begin
                n.prdata[4:0] = r.ctrl;
            end else if (!i_pwrite && sel == hsf_pkg::HSF_SEL_STAT) begin
                n.prdata[hsf_pkg::STAT_LN_LSB +: hsf_pkg::LN_W] = r.ln;
                n.prdata[hsf_pkg::STAT_TRIPLET_LSB +: 3] = r.det_triplet;
                n.prdata[hsf_pkg::STAT_LVL_LSB +: LVL_W] = level;
            end
        end
        if (i_psel && i_penable && i_pwrite && sel == hsf_pkg::HSF_SEL_CTRL) begin
            n.ctrl = i_pwdata[4:0];
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            r <= '0;
            r.ctrl <= hsf_pkg::CTRL_RST;
            r.act <= hsf_pkg::CTRL_RST;
            // counting starts at line one, as after a clear edge
            r.ln <= hsf_pkg::LN_FIRST;
        end else begin
            r <= n;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // zero wait states: read data was already captured in the setup cycle
    assign o_pready = i_psel & i_penable;
    assign o_prdata = r.prdata;
    assign o_pslverr = r.pslverr & i_psel & i_penable;

    // stream valid and word come straight from flip-flops
    assign o_out_valid = r.out_valid;
    assign o_formatted_word_out = r.out_word;
    // whole bus released while the drive pin is high
    assign o_formatted_word_oe = {20{~i_out_bus_drive_n}};

endmodule

//--- verif/hsf_fmt_asserts.sv
// port assertions for the stream formatter control block
// assumes it is bound into hsf_formatter and sees only its ports
`timescale 1ns/10ps
module hsf_fmt_asserts (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_in_ready,
    input wire logic i_out_bus_drive_n,
    input wire logic i_out_ready,
    input wire logic o_out_valid,
    input wire logic [19:0] o_formatted_word_out,
    input wire logic [19:0] o_formatted_word_oe
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    logic rd_acc;
    assign rd_acc = i_psel && i_penable && !i_pwrite;
    // ********
    // bus, output pins, stream
    // ********
    oe_follow_a: assert property (o_formatted_word_oe == {20{!i_out_bus_drive_n}})
        else $error("output enable does not follow its pin");
    pready_acc_a: assert property (i_psel && i_penable |-> o_pready)
        else $error("no ready in access cycle");
    pready_setup_a: assert property (i_psel && !i_penable |-> !o_pready)
        else $error("ready during setup cycle");
    err_place_a: assert property (o_pslverr |-> i_psel && i_penable)
        else $error("slave error outside access");
    err_read_a: assert property (rd_acc && i_paddr != hsf_pkg::CTRL_ADDR && i_paddr != hsf_pkg::STAT_ADDR
        |-> o_pslverr && o_prdata == 32'h0)
        else $error("unmapped read not refused");
    ctrl_upper_a: assert property (rd_acc && i_paddr == hsf_pkg::CTRL_ADDR |-> o_prdata[31:5] == 27'h0 && !o_pslverr)
        else $error("control read shows upper bits");
    ln_nonzero_a: assert property (rd_acc && i_paddr == hsf_pkg::STAT_ADDR |-> o_prdata[10:0] != 11'h0)
        else $error("line number reads zero");
    out_hold_a: assert property (o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_formatted_word_out))
        else $error("output word dropped while stalled");
    valid_start_a: assert property ($fell(i_sys_rst) |-> !o_out_valid [*6])
        else $error("output word too early after reset");
    cover property (o_out_valid && i_out_ready && o_formatted_word_out[19:10] == 10'h3ff);
    cover property (!o_in_ready);
    cover property (o_pslverr);
    cover property (o_out_valid && !i_out_ready);
endmodule

bind hsf_formatter hsf_fmt_asserts u_chk (.i_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .o_prdata, .o_pready, .o_pslverr, .o_in_ready, .i_out_bus_drive_n, .i_out_ready, .o_out_valid,
    .o_formatted_word_out, .o_formatted_word_oe);

//--- verif/hsf_vid_partner.sv
// upstream video source and downstream serializer model
// assumes the bench calls its tasks right after a rising clock edge
`timescale 1ns/10ps
module hsf_vid_partner (
    input wire logic i_clk,
    input wire logic i_in_ready,
    input wire logic i_out_valid,
    input wire logic [19:0] i_word,
    input wire logic [19:0] i_oe,
    output hsf_pkg::hsf_word_t o_src,
    output logic o_in_valid,
    output logic o_clear,
    output logic o_out_ready
);
    logic [19:0] cap [$];
    wire logic [19:0] bus_lvl;
    logic hold;
    logic slow;
    logic [1:0] cnt;
    int n_push;
    int n_cap;
    int n_stuck;
    initial begin
        o_src = '0;
        o_in_valid = 1'b0;
        o_clear = 1'b0;
        o_out_ready = 1'b0;
        hold = 1'b0;
        slow = 1'b0;
        cnt = 2'h0;
        n_push = 0;
        n_cap = 0;
        n_stuck = 0;
    end
    for (genvar k = 0; k < 20; k++) begin : g_pin
        assign bus_lvl[k] = i_oe[k] ? i_word[k] : 1'bz;
    end
    // the slow mode refuses one word in four, hold refuses all
    always @(posedge i_clk) begin
        if (i_out_valid && o_out_ready) begin
            cap.push_back(bus_lvl);
            n_cap++;
        end
        cnt <= cnt + 2'h1;
        o_out_ready <= !hold && !(slow && cnt == 2'h3);
    end
    function automatic logic [9:0] xyz(input logic f, v, h);
        return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h, 2'h0};
    endfunction
    task automatic push(input logic f, v, h, input logic [9:0] y, c);
        int k;
        o_src <= {f, v, h, y, c};
        o_in_valid <= 1'b1;
        for (k = 0; k < 300; k++) begin
            @(posedge i_clk);
            if (i_in_ready) break;
        end
        if (k == 300) n_stuck++;
        n_push++;
    endtask
    // sixteen blanking words, then eight active
    task automatic line(input logic f, v, emb);
        int j;
        logic [9:0] y;
        for (j = 0; j < 24; j++) begin
            y = (j < 16) ? 10'h040 : 10'h1a5 + 10'(j);
            if (emb && (j < 4 || (j >= 12 && j < 16))) begin
                y = (j % 4 == 0) ? 10'h3ff : (j % 4 == 3) ? xyz(f, v, j < 4) : 10'h000;
                push(f, v, j < 16, y, y);
            end else begin
                push(f, v, j < 16, y, (j < 16) ? 10'h200 : 10'h0d2 + 10'(j));
            end
        end
        o_in_valid <= 1'b0;
        @(posedge i_clk);
    endtask
    // leaves the last refused word offered
    task automatic fill();
        int k;
        o_src <= {3'h0, 10'h1a5, 10'h0d2};
        o_in_valid <= 1'b1;
        for (k = 0; k < 64; k++) begin
            @(posedge i_clk);
            if (!i_in_ready) break;
            n_push++;
        end
    endtask
    task automatic clear_line();
        o_clear <= 1'b1;
        @(posedge i_clk);
        o_clear <= 1'b0;
        @(posedge i_clk);
    endtask
endmodule

//--- verif/tb_hsf_formatter.sv
// self-checking bench for the stream formatter control block
// assumes hsf_vid_partner on the stream side and an apb master here
`timescale 1ns/10ps
module tb_hsf_formatter;
    logic clk, rst, psel, penable, pwrite, drive_n, err, clr, in_valid, in_ready, out_valid, out_ready, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [19:0] word, oe;
    hsf_pkg::hsf_word_t src;
    int fails, n_checks, p;
    logic f, v, emb;
    logic [4:0] p_ctrl [6] = '{5'h07, 5'h00, 5'h05, 5'h03, 5'h1f, 5'h09};
    logic [2:0] p_fve [6] = '{3'b000, 3'b000, 3'b110, 3'b000, 3'b011, 3'b001};
    hsf_formatter dut (.i_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_video_word_in({src.y, src.c}), .i_line_blank_mark(src.h), .i_picture_blank_mark(src.v),
        .i_interlace_odd_mark(src.f), .i_in_valid(in_valid), .o_in_ready(in_ready), .i_line_counter_clear(clr),
        .i_out_bus_drive_n(drive_n), .i_out_ready(out_ready), .o_out_valid(out_valid),
        .o_formatted_word_out(word), .o_formatted_word_oe(oe));
    hsf_vid_partner u_part (.i_clk(clk), .i_in_ready(in_ready), .i_out_valid(out_valid), .i_word(word),
        .i_oe(oe), .o_src(src), .o_in_valid(in_valid), .o_clear(clr), .o_out_ready(out_ready));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ********
    // shared tasks
    // ********
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [32:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (k == 50) begin
            fails++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // five words stay in the pipe until more input arrives
    task automatic drain();
        int k;
        for (k = 0; k < 3000; k++) begin
            @(posedge clk);
            if (u_part.n_cap == u_part.n_push - 5) break;
        end
        if (k == 3000) begin
            fails++;
            finish_test();
        end
    endtask
    task automatic scan(input logic [4:0] ctl, input logic f, v);
        int i, n;
        logic ln;
        logic [9:0] e;
        logic [19:0] w [$];
        w = u_part.cap;
        n = 0;
        ln = ctl[1] && !ctl[3];
        for (i = 0; i + 3 < w.size(); i++) begin
            if (w[i][19:10] === 10'h3ff && w[i+1][19:10] === 10'h0 && w[i+2][19:10] === 10'h0) begin
                n++;
                e = u_part.xyz(f, v, n == 1);
                check(w[i+3], {e, e});
                check({w[i][9:0], w[i+1][9:0]}, 20'hffc00);
                if (n == 1 && i + 7 < w.size()) begin
                    check(w[i+4], ln ? {2{10'h204}} : {10'h040, 10'h200});
                    check(w[i+5], ln ? {2{10'h200}} : {10'h040, 10'h200});
                    if (ctl[2]) begin
                        check({w[i+6][19] ^ w[i+6][18], w[i+6][9] ^ w[i+6][8], w[i+7][19] ^ w[i+7][18],
                            w[i+7][9] ^ w[i+7][8]}, 4'hf);
                    end else begin
                        check(w[i+6], {10'h040, 10'h200});
                    end
                end
            end
        end
        check(n, ctl[0] ? 2 : 0);
        if (ln) begin
            apb(1'b0, hsf_pkg::STAT_ADDR, 32'h0);
            check(rd[10:0], 11'h002);
        end
    endtask
    // ********
    // main sequence
    // ********
    initial begin
        fails = 0;
        n_checks = 0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        drive_n = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check(oe, 20'h0);
        drive_n <= 1'b0;
        @(posedge clk);
        check(oe, 20'hfffff);
        apb(1'b0, hsf_pkg::CTRL_ADDR, 32'h0);
        check(rd, {27'h0, hsf_pkg::CTRL_RST});
        apb(1'b0, hsf_pkg::STAT_ADDR, 32'h0);
        check({rd[20:16], rd[10:0]}, 16'h0001);
        apb(1'b0, 8'h08, 32'h0);
        check({err, rd}, 33'h100000000);
        apb(1'b1, 8'h10, 32'h0);
        apb(1'b1, hsf_pkg::STAT_ADDR, 32'hffffffff);
        check(err, 1'b0);
        apb(1'b0, hsf_pkg::CTRL_ADDR, 32'h0);
        check(rd, {27'h0, hsf_pkg::CTRL_RST});
        for (p = 0; p < 6; p++) begin
            {f, v, emb} = p_fve[p];
            u_part.slow <= (p >= 2);
            apb(1'b1, hsf_pkg::CTRL_ADDR, {27'h0, p_ctrl[p]});
            u_part.line(f, v, emb);
            drain();
            u_part.cap.delete();
            u_part.clear_line();
            apb(1'b0, hsf_pkg::STAT_ADDR, 32'h0);
            check(rd[10:0], 11'h001);
            u_part.line(f, v, emb);
            drain();
            scan(p_ctrl[p], f, v);
        end
        u_part.hold <= 1'b1;
        @(posedge clk);
        u_part.fill();
        apb(1'b0, hsf_pkg::STAT_ADDR, 32'h0);
        check({in_ready, rd[20:16]}, 6'h10);
        u_part.hold <= 1'b0;
        u_part.push(1'b0, 1'b0, 1'b0, 10'h1a5, 10'h0d2);
        u_part.line(1'b0, 1'b0, 1'b0);
        drain();
        check(u_part.n_stuck, 0);
        finish_test();
    end
endmodule
